// file: design/gpio_bank_map.vh
// Register map, field layout and timing constants of the GPIO bank
// Functional notes
// - direction bit 0 output, 1 input
// - direction resets FFh, data and invert 00h
// - output bits readable, writable, driven to pin
// - input bits read pin, writes ignored
// - invert bit flips data to pin relation
// - LED mode 00 floats, 01 drives low
// - LED mode 10 gives 1 Hz square wave
// - LED mode 11 gives quarter hertz wave
// - odd select bits route LED to port_d
// - even select bits route watchdog timeout
// - port works only while activation bit set
`ifndef GPIO_BANK_MAP_VH
`define GPIO_BANK_MAP_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define IDX_ACTIVATE 8'h30
`define IDX_B_DIR 8'hE3
`define IDX_B_DATA 8'hE4
`define IDX_B_INV 8'hE5
`define IDX_C_DIR 8'hF0
`define IDX_C_DATA 8'hF1
`define IDX_C_INV 8'hF2
`define IDX_LED_MODE 8'hF3
`define IDX_D_DIR 8'hF4
`define IDX_D_DATA 8'hF5
`define IDX_D_INV 8'hF6
`define IDX_D_ALT 8'hF7

// ****************************************
// Reset values and fields
// ****************************************
`define RST_DIR 8'hFF
`define RST_DATA 8'h00
`define RST_INV 8'h00
`define RST_LED 2'h0
`define RST_ALT 8'h00
`define RST_ACT 3'h0
`define ACT_B 0
`define ACT_C 1
`define ACT_D 2
`define LED_MSB 7
`define LED_LSB 6
`define LED_FLOAT 2'h0
`define LED_LOW 2'h1
`define LED_BLINK_1HZ 2'h2
`define LED_BLINK_QHZ 2'h3
`define ALT_LED_BITS 8'hAA
`define ALT_WDT_BITS 8'h55
`define QHZ_DIV_LAST 2'h3

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 5
`define LED_1HZ_HALF_NS 500000000
`define LED_1HZ_HALF_CYC (`LED_1HZ_HALF_NS / `CLK_PERIOD_NS)

`endif

// file: design/led_blinker.v
// Suspend indicator LED pattern generator
`include "gpio_bank_map.vh"

module led_blinker #(
  parameter HALF_CYC = `LED_1HZ_HALF_CYC,
  parameter CW = 27
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Mode and LED pin
  input wire [1:0] mode,
  output reg led_out,
  output reg led_oe
);

  // ****************************************
  // Free running dividers
  // ****************************************
  // Dividers never stop, so a mode change picks up the running phase
  reg [CW-1:0] count;
  reg [1:0] slow_div;
  reg wave_1hz;
  reg wave_qhz;
  wire half_done = (count == HALF_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= {CW{1'b0}};
      slow_div <= 2'h0;
      wave_1hz <= 1'b0;
      wave_qhz <= 1'b0;
    end else if (half_done) begin
      count <= {CW{1'b0}};
      wave_1hz <= ~wave_1hz;
      slow_div <= slow_div + 2'h1;
      if (slow_div == `QHZ_DIV_LAST) begin
        wave_qhz <= ~wave_qhz;
      end
    end else begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // Pin stage
  // ****************************************
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      led_out <= 1'b0;
      led_oe <= 1'b0;
    end else begin
      case (mode)
        `LED_FLOAT: begin
          led_out <= 1'b0;
          led_oe <= 1'b0;
        end
        `LED_LOW: begin
          led_out <= 1'b0;
          led_oe <= 1'b1;
        end
        `LED_BLINK_1HZ: begin
          led_out <= wave_1hz;
          led_oe <= 1'b1;
        end
        default: begin
          led_out <= wave_qhz;
          led_oe <= 1'b1;
        end
      endcase
    end
  end

endmodule

// file: design/gpio_port_pins.v
// Pin driver stage of one 8-bit general purpose port
module gpio_port_pins #(
  parameter W = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Configuration
  input wire active,
  input wire [W-1:0] direction,
  input wire [W-1:0] data,
  input wire [W-1:0] invert,
  // Alternate function
  input wire [W-1:0] alt_sel,
  input wire [W-1:0] alt_out,
  input wire [W-1:0] alt_oe,
  // Pins
  output reg [W-1:0] pin_out,
  output reg [W-1:0] pin_oe
);

  // ****************************************
  // Output mux
  // ****************************************
  reg [W-1:0] next_out;
  reg [W-1:0] next_oe;
  integer i;

  always @* begin
    next_out = {W{1'b0}};
    next_oe = {W{1'b0}};
    for (i = 0; i < W; i = i + 1) begin
      if (!active) begin
        next_oe[i] = 1'b0;
      end else if (alt_sel[i]) begin
        next_out[i] = alt_out[i];
        next_oe[i] = alt_oe[i];
      end else begin
        next_out[i] = data[i] ^ invert[i];
        next_oe[i] = ~direction[i];
      end
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= {W{1'b0}};
      pin_oe <= {W{1'b0}};
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end

endmodule

// file: design/gpio_bank.v
// GPIO bank top: APB register file, three ports and suspend LED routing
//
// Decided for this implementation: the APB interface to the registers.
`include "gpio_bank_map.vh"

module gpio_bank #(
  parameter W = 8,
  parameter LED_HALF_CYC = `LED_1HZ_HALF_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Port B pins
  input wire [W-1:0] port_b_in,
  output wire [W-1:0] port_b_out,
  output wire [W-1:0] port_b_oe,
  // Port C pins
  input wire [W-1:0] port_c_in,
  output wire [W-1:0] port_c_out,
  output wire [W-1:0] port_c_oe,
  // Port D pins
  input wire [W-1:0] port_d_in,
  output wire [W-1:0] port_d_out,
  output wire [W-1:0] port_d_oe,
  // Watchdog timeout from the watchdog block
  input wire watchdog_timeout_out_n,
  // Dedicated suspend LED pin
  output wire sleep_indicator_led_out,
  output wire sleep_indicator_led_oe
);

  // ****************************************
  // Register state
  // ****************************************
  reg [2:0] activate;
  reg [W-1:0] b_dir;
  reg [W-1:0] b_data;
  reg [W-1:0] b_inv;
  reg [W-1:0] c_dir;
  reg [W-1:0] c_data;
  reg [W-1:0] c_inv;
  reg [1:0] led_mode;
  reg [W-1:0] d_dir;
  reg [W-1:0] d_data;
  reg [W-1:0] d_inv;
  reg [W-1:0] d_alt;
  reg wdt_level;

  // ****************************************
  // Helpers
  // ****************************************
  // Index is valid only for an aligned word below the top of the map
  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a[1:0] == 2'h0) && (a[11:10] == 2'h0);
    end
  endfunction

  function mapped;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_ACTIVATE, `IDX_B_DIR, `IDX_B_DATA, `IDX_B_INV,
        `IDX_C_DIR, `IDX_C_DATA, `IDX_C_INV, `IDX_LED_MODE,
        `IDX_D_DIR, `IDX_D_DATA, `IDX_D_INV, `IDX_D_ALT: begin
          mapped = 1'b1;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  endfunction

  // Data view: output bits show the stored value, input bits the pin XOR the invert bit
  function [W-1:0] data_view;
    input [W-1:0] dir;
    input [W-1:0] stored;
    input [W-1:0] pin;
    input [W-1:0] inv;
    begin
      data_view = (~dir & stored) | (dir & (pin ^ inv));
    end
  endfunction

  // Writes land only on bits configured as outputs
  function [W-1:0] data_write;
    input [W-1:0] dir;
    input [W-1:0] stored;
    input [W-1:0] wdata;
    begin
      data_write = (dir & stored) | (~dir & wdata);
    end
  endfunction

  // ****************************************
  // APB handshake
  // ****************************************
  wire [7:0] idx = paddr[9:2];
  wire hit = addr_ok(paddr) && mapped(idx);
  wire [W-1:0] wbyte = pwdata[W-1:0];
  wire wr_go = psel && penable && pready && pwrite && hit;
  reg [31:0] next_rdata;

  // One wait state: ready rises in the second access cycle, with data
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~hit;
      prdata <= pwrite ? 32'h0 : next_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always @* begin
    next_rdata = 32'h0;
    if (addr_ok(paddr)) begin
      case (idx)
        `IDX_ACTIVATE: begin
          next_rdata[2:0] = activate;
        end
        `IDX_B_DIR: begin
          next_rdata[W-1:0] = b_dir;
        end
        `IDX_B_DATA: begin
          next_rdata[W-1:0] = data_view(b_dir, b_data, port_b_in, b_inv);
        end
        `IDX_B_INV: begin
          next_rdata[W-1:0] = b_inv;
        end
        `IDX_C_DIR: begin
          next_rdata[W-1:0] = c_dir;
        end
        `IDX_C_DATA: begin
          next_rdata[W-1:0] = data_view(c_dir, c_data, port_c_in, c_inv);
        end
        `IDX_C_INV: begin
          next_rdata[W-1:0] = c_inv;
        end
        `IDX_LED_MODE: begin
          next_rdata[`LED_MSB:`LED_LSB] = led_mode;
        end
        `IDX_D_DIR: begin
          next_rdata[W-1:0] = d_dir;
        end
        `IDX_D_DATA: begin
          next_rdata[W-1:0] = data_view(d_dir, d_data, port_d_in, d_inv);
        end
        `IDX_D_INV: begin
          next_rdata[W-1:0] = d_inv;
        end
        `IDX_D_ALT: begin
          next_rdata[W-1:0] = d_alt;
        end
        default: begin
          next_rdata = 32'h0;
        end
      endcase
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      activate <= `RST_ACT;
      b_dir <= `RST_DIR;
      b_data <= `RST_DATA;
      b_inv <= `RST_INV;
      c_dir <= `RST_DIR;
      c_data <= `RST_DATA;
      c_inv <= `RST_INV;
      led_mode <= `RST_LED;
      d_dir <= `RST_DIR;
      d_data <= `RST_DATA;
      d_inv <= `RST_INV;
      d_alt <= `RST_ALT;
    end else if (wr_go) begin
      case (idx)
        `IDX_ACTIVATE: begin
          activate <= wbyte[2:0];
        end
        `IDX_B_DIR: begin
          b_dir <= wbyte;
        end
        `IDX_B_DATA: begin
          b_data <= data_write(b_dir, b_data, wbyte);
        end
        `IDX_B_INV: begin
          b_inv <= wbyte;
        end
        `IDX_C_DIR: begin
          c_dir <= wbyte;
        end
        `IDX_C_DATA: begin
          c_data <= data_write(c_dir, c_data, wbyte);
        end
        `IDX_C_INV: begin
          c_inv <= wbyte;
        end
        `IDX_LED_MODE: begin
          led_mode <= wbyte[`LED_MSB:`LED_LSB];
        end
        `IDX_D_DIR: begin
          d_dir <= wbyte;
        end
        `IDX_D_DATA: begin
          d_data <= data_write(d_dir, d_data, wbyte);
        end
        `IDX_D_INV: begin
          d_inv <= wbyte;
        end
        `IDX_D_ALT: begin
          d_alt <= wbyte;
        end
        default: begin
          d_alt <= d_alt;
        end
      endcase
    end
  end

  // ****************************************
  // Suspend LED
  // ****************************************
  wire led_out_raw;
  wire led_oe_raw;

  led_blinker #(
    .HALF_CYC(LED_HALF_CYC),
    .CW(27)
  ) u_led (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .mode(led_mode),
    .led_out(led_out_raw),
    .led_oe(led_oe_raw)
  );

  // Dedicated pin gets a register stage so it lines up with port D
  reg led_pin_out;
  reg led_pin_oe;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      led_pin_out <= 1'b0;
      led_pin_oe <= 1'b0;
      wdt_level <= 1'b1;
    end else begin
      led_pin_out <= led_out_raw;
      led_pin_oe <= led_oe_raw;
      wdt_level <= watchdog_timeout_out_n;
    end
  end

  assign sleep_indicator_led_out = led_pin_out;
  assign sleep_indicator_led_oe = led_pin_oe;

  // ****************************************
  // Alternate functions on port D
  // ****************************************
  // Odd bits carry the LED, even bits the watchdog timeout
  wire [W-1:0] alt_out = ({W{led_out_raw}} & `ALT_LED_BITS) |
    ({W{wdt_level}} & `ALT_WDT_BITS);
  wire [W-1:0] alt_oe = ({W{led_oe_raw}} & `ALT_LED_BITS) | `ALT_WDT_BITS;

  // ****************************************
  // Ports
  // ****************************************
  gpio_port_pins #(.W(W)) u_port_b (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .active(activate[`ACT_B]),
    .direction(b_dir),
    .data(b_data),
    .invert(b_inv),
    .alt_sel({W{1'b0}}),
    .alt_out({W{1'b0}}),
    .alt_oe({W{1'b0}}),
    .pin_out(port_b_out),
    .pin_oe(port_b_oe)
  );

  gpio_port_pins #(.W(W)) u_port_c (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .active(activate[`ACT_C]),
    .direction(c_dir),
    .data(c_data),
    .invert(c_inv),
    .alt_sel({W{1'b0}}),
    .alt_out({W{1'b0}}),
    .alt_oe({W{1'b0}}),
    .pin_out(port_c_out),
    .pin_oe(port_c_oe)
  );

  gpio_port_pins #(.W(W)) u_port_d (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .active(activate[`ACT_D]),
    .direction(d_dir),
    .data(d_data),
    .invert(d_inv),
    .alt_sel(d_alt),
    .alt_out(alt_out),
    .alt_oe(alt_oe),
    .pin_out(port_d_out),
    .pin_oe(port_d_oe)
  );

endmodule

// file: bench/gpio_bank_asserts.sv
// Port level checks of the GPIO bank
`include "gpio_bank_map.vh"
module gpio_bank_asserts #(
  parameter W = 8,
  parameter LED_HALF_CYC = `LED_1HZ_HALF_CYC
) (
  // Clock, reset and APB
  input wire ref_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Pins
  input wire [W-1:0] port_b_oe,
  input wire [W-1:0] port_c_oe,
  input wire [W-1:0] port_d_oe,
  input wire sleep_indicator_led_out,
  input wire sleep_indicator_led_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic prev;
  logic [1:0] mode_q;
  logic [1:0] seen;
  int cnt;
  wire done = psel && penable && pready && pwrite;
  wire led_wr = done && paddr == {2'h0, `IDX_LED_MODE, 2'h0};
  wire act_wr = done && paddr == {2'h0, `IDX_ACTIVATE, 2'h0};
  wire chg = sleep_indicator_led_out != prev;
  // Period is judged only after three edges in one mode: the divider phase is free running
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev <= 1'b0;
      cnt <= 0;
      mode_q <= 2'h0;
      seen <= 2'h0;
    end else begin
      prev <= sleep_indicator_led_out;
      cnt <= chg ? 1 : cnt + 1;
      if (led_wr) begin
        mode_q <= pwdata[7:6];
        seen <= 2'h0;
      end else if (chg && seen != 2'h3) begin
        seen <= seen + 2'h1;
      end
    end
  end
  property p_one_wait; psel && penable && !pready |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused access not clean");
  property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside answer");
  property p_led_float; led_wr && pwdata[7:6] == `LED_FLOAT |-> ##3 !sleep_indicator_led_oe;
  endproperty
  a_led_float: assert property (p_led_float) else $error("led not floating");
  property p_led_low; led_wr && pwdata[7:6] == `LED_LOW
    |-> ##3 sleep_indicator_led_oe && !sleep_indicator_led_out; endproperty
  a_led_low: assert property (p_led_low) else $error("led not driven low");
  property p_blink_1hz; mode_q == `LED_BLINK_1HZ && seen == 2'h3 && chg
    |-> cnt == LED_HALF_CYC; endproperty
  a_blink_1hz: assert property (p_blink_1hz) else $error("fast blink period wrong");
  property p_blink_qhz; mode_q == `LED_BLINK_QHZ && seen == 2'h3 && chg
    |-> cnt == 4 * LED_HALF_CYC; endproperty
  a_blink_qhz: assert property (p_blink_qhz) else $error("slow blink period wrong");
  property p_reset_idle; $rose(resetn) |-> {port_b_oe, port_c_oe, port_d_oe} == 0; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pin driven after reset");
  property p_inactive; act_wr && pwdata[2:0] == 3'h0
    |-> ##3 {port_b_oe, port_c_oe, port_d_oe} == 0; endproperty
  a_inactive: assert property (p_inactive) else $error("inactive port drives");
endmodule
bind gpio_bank gpio_bank_asserts #(.W(W), .LED_HALF_CYC(LED_HALF_CYC)) gpio_bank_asserts_inst (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .port_b_oe(port_b_oe), .port_c_oe(port_c_oe), .port_d_oe(port_d_oe),
  .sleep_indicator_led_out(sleep_indicator_led_out),
  .sleep_indicator_led_oe(sleep_indicator_led_oe));

// file: bench/pin_model.sv
// Board side of one port: pins read back what is driven, else the board level
module pin_model (
  // Device side
  input wire logic [7:0] drive,
  input wire logic [7:0] enable,
  // Board side
  input wire logic [7:0] board,
  output logic [7:0] level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released bits fall to the board pattern, never keep the last driven value
  assign level = (enable & drive) | (~enable & board);
endmodule

// file: bench/gpio_bank_tb.sv
// Self-checking bench of the GPIO bank
`include "gpio_bank_map.vh"
module gpio_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, wd_n = 1, led_out, led_oe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ev, last;
  logic [7:0] ext = 8'h3C, rv;
  logic [7:0] pin_in [3], pout [3], poe [3];
  logic [7:0] base [3] = '{`IDX_B_DIR, `IDX_C_DIR, `IDX_D_DIR};
  int tog [4] = '{0, 0, 16, 4};
  int bad_count = 0, comparisons = 0, cycles = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  gpio_bank #(.LED_HALF_CYC(10)) gpio_bank_inst (.ref_clk(ref_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .port_b_in(pin_in[0]), .port_b_out(pout[0]), .port_b_oe(poe[0]),
    .port_c_in(pin_in[1]), .port_c_out(pout[1]), .port_c_oe(poe[1]),
    .port_d_in(pin_in[2]), .port_d_out(pout[2]), .port_d_oe(poe[2]),
    .watchdog_timeout_out_n(wd_n),
    .sleep_indicator_led_out(led_out), .sleep_indicator_led_oe(led_oe));
  for (genvar g = 0; g < 3; g++) begin : pins
    pin_model pin_model_inst (.drive(pout[g]), .enable(poe[g]), .board(ext),
      .level(pin_in[g]));
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ****************************************
  // APB master
  // ****************************************
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, {2'h0, i, 2'h0}, d, rv, ev);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    xfer(1'b0, {2'h0, i, 2'h0}, 8'h00, rv, ev);
    chk(rv, exp);
  endtask
  // Pins settle two edges after the completing edge; two spare
  task automatic settle;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      $display("[ERR] %0t run too long", $time);
      finish_test;
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      rd(base[p], `RST_DIR);
      rd(base[p] + 8'h02, `RST_INV);
    end
    rd(`IDX_LED_MODE, 8'h00);
    rd(`IDX_D_ALT, `RST_ALT);
    rd(`IDX_ACTIVATE, 8'h00);
    xfer(1'b0, 12'h000, 8'h00, rv, ev);
    chk({7'h00, ev}, 8'h01);
    xfer(1'b0, {2'h0, `IDX_B_DIR, 2'h1}, 8'h00, rv, ev);
    chk({7'h00, ev}, 8'h01);
    $display("reset and map test done");
    wr(`IDX_ACTIVATE, 8'h07);
    for (int p = 0; p < 3; p++) begin
      wr(base[p], 8'h00);
      settle();
      rd(base[p] + 8'h01, 8'h00);
      chk(poe[p], 8'hFF);
      chk(pout[p], 8'h00);
      wr(base[p], 8'hF0);
      wr(base[p] + 8'h01, 8'hA5);
      rd(base[p] + 8'h01, 8'h35);
      settle();
      chk(poe[p], 8'h0F);
      chk(pout[p] & 8'h0F, 8'h05);
      wr(base[p] + 8'h02, 8'hFF);
      rd(base[p] + 8'h01, 8'hC5);
      settle();
      chk(pout[p] & 8'h0F, 8'h0A);
      wr(base[p], 8'h00);
      rd(base[p] + 8'h01, 8'h05);
      settle();
      chk(pout[p], 8'hFA);
      wr(base[p] + 8'h02, 8'h00);
      wr(base[p], 8'hFF);
      settle();
      chk(poe[p], 8'h00);
      $display("port %0d test done", p);
    end
    wr(base[0], 8'h00);
    wr(`IDX_ACTIVATE, 8'h00);
    settle();
    chk(poe[0], 8'h00);
    wr(`IDX_ACTIVATE, 8'h07);
    settle();
    chk(poe[0], 8'hFF);
    $display("activation test done");
    for (int m = 0; m < 4; m++) begin
      wr(`IDX_LED_MODE, {m[1:0], 6'h00});
      rd(`IDX_LED_MODE, {m[1:0], 6'h00});
      repeat (5) @(posedge ref_clk);
      n = 0;
      last = led_out;
      repeat (160) begin
        @(posedge ref_clk);
        if (led_out !== last) n++;
        last = led_out;
      end
      chk({7'h00, led_oe}, {7'h00, m != 0});
      if (m == 1) chk({7'h00, led_out}, 8'h00);
      if (m > 0) chk(n[7:0], tog[m][7:0]);
    end
    $display("led test done");
    wr(`IDX_LED_MODE, 8'h40);
    wr(`IDX_D_ALT, 8'hFF);
    rd(`IDX_D_ALT, 8'hFF);
    settle();
    chk(poe[2], 8'hFF);
    chk(pout[2], 8'h55);
    wd_n <= 1'b0;
    settle();
    chk(pout[2], 8'h00);
    wr(`IDX_LED_MODE, 8'h00);
    settle();
    chk(poe[2], 8'h55);
    wr(`IDX_D_ALT, 8'h00);
    settle();
    chk(poe[2], 8'h00);
    $display("alternate function test done");
    finish_test;
  end
endmodule
